// File: epw_cfg.svh
`ifndef EPW_CFG_SVH
`define EPW_CFG_SVH
// ----------------------------------------
// Widths
// ----------------------------------------
`define EPW_ADDR_W          13
`define EPW_DATA_W          8
`define EPW_ROW_LSB         6
`define EPW_PAGE_BYTES      64
// ----------------------------------------
// Timing, figures as printed
// ----------------------------------------
`define EPW_CLK_NS          100
`define EPW_STROBE_NS       150
`define EPW_SETUP_NS        50
`define EPW_HOLD_NS         150
`define EPW_LOAD_GAP_NS     200
`define EPW_READ_NS         350
`define EPW_LOAD_TO_POLL_NS 200
`define EPW_WINDOW_US       200
`define EPW_PROGRAM_MS      10
// ----------------------------------------
// Cycle counts, least times round up
// ----------------------------------------
`define EPW_CDIV(t)         (((t) + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_STROBE_CYC      `EPW_CDIV(`EPW_STROBE_NS)
`define EPW_SETUP_CYC       `EPW_CDIV(`EPW_SETUP_NS)
`define EPW_HOLD_CYC        `EPW_CDIV(`EPW_HOLD_NS)
`define EPW_LOAD_GAP_CYC    `EPW_CDIV(`EPW_LOAD_GAP_NS)
`define EPW_READ_CYC        `EPW_CDIV(`EPW_READ_NS)
`define EPW_POLL_DLY_CYC    `EPW_CDIV(`EPW_LOAD_TO_POLL_NS)
`define EPW_WINDOW_CYC      `EPW_CDIV(`EPW_WINDOW_US * 1000)
`define EPW_PROGRAM_CYC     `EPW_CDIV(`EPW_PROGRAM_MS * 1000000)
`define EPW_CNT_W           20
`endif

// File: epw_dev_model.sv
`timescale 1ns/1ps
module epw_dev_model
   import epw_pkg::*;
#(
   parameter int WIN  = 2000,
   parameter int PROG = 600
)
(
   // Host side
   input  wire epw_pin_type pins,
   input  wire logic        mclk,
   output logic [7:0]       dq_in
);
   logic [7:0]  mem [0:8191];
   logic [7:0]  pg [0:63];
   logic [63:0] pv;
   logic [12:0] wa;
   logic [6:0]  row;
   logic [7:0]  last;
   logic [7:0]  junk;
   logic        go;
   logic        open;
   logic        busy;
   int          tmr;
   int          oecnt;
   realtime     tf;
   wire lo = !pins.wr_strobe_n && !pins.chip_sel_n;
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      {go, open, busy, pv, junk} = '0;
      tmr = 0;
      oecnt = 0;
   end
   // Later fall of select or strobe opens a load; busy refuses
   always @(posedge lo) if (pins.out_gate_n && !busy) begin
      go = 1'b1;
      tf = $realtime;
      wa = pins.addr;
   end
   // Earlier rise latches data; short pulses are noise
   always @(negedge lo) if (go) begin
      go = 1'b0;
      if ($realtime - tf >= 20.0) begin
         if (!open) row = wa[12:6];
         open = 1'b1;
         last = pins.dq_out;
         pg[wa[5:0]] = last;
         pv[wa[5:0]] = 1'b1;
      end
   end
   // Timer cleared while a load is open, quiet window starts program
   always @(posedge mclk) begin
      if (go) tmr = 0;
      else if (open && !busy && ++tmr >= WIN) begin
         busy = 1'b1;
         tmr = 0;
      end else if (busy && ++tmr >= PROG) begin
         foreach (pg[i]) if (pv[i]) mem[{row, 6'(i)}] = pg[i];
         {busy, open, pv} = '0;
         tmr = 0;
      end
   end
   // Released bus shows a moving pattern; access takes two cycles
   always @(posedge mclk) begin
      junk = junk + 8'h35;
      oecnt = (!pins.chip_sel_n && !pins.out_gate_n) ? oecnt + 1 : 0;
      dq_in <= oecnt < 2 ? junk : open ? ~last : mem[pins.addr];
   end
endmodule

// File: epw_host.sv
`timescale 1ns/1ps
`include "epw_cfg.svh"
// Summary of operation
// R01 - Device latches data, starts timer on strobe rise
// R02 - New strobe fall or low strobe resets timer
// R03 - Quiet window after last byte starts program
// R04 - Program ends within 10 ms; writes ignored
// R05 - Holding strobe low stretches page load
// R06 - Host loads bytes at window rate or stretches
// R07 - Read during program returns inverted last byte
// R08 - After program, true byte; host polls until match
// R09 - Poll allowed mid-load; returns inverted latest byte
// R10 - Poll read uses ordinary read timing
// R11 - Non-write pin combinations inhibit writing
// R12 - After power-up, fresh strobe fall re-enables writes
// R13 - Strobe pulses under 20 ns are ignored
// R14 - Loads 0.2 us apart; device waits 200 us
// R15 - Polling data valid 200 ns after last load
// R16 - Write: select low, strobe low, gate high
// R17 - Address at later fall, data at earlier rise
// R18 - Row address fixed by first byte of page
// R19 - Page holds 1 to 64 bytes, any order
// R20 - After program, device idles, accepts next page
module epw_host
   import epw_pkg::*;
(
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   // Request side
   input  wire logic         req_valid,
   input  wire epw_req_type  req,
   output logic              req_ready,
   output logic              rsp_valid,
   output epw_rsp_type       rsp,
   output logic              page_error,
   // Device pins
   output epw_pin_type       pins,
   input  wire logic [7:0]   dq_in
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_WSETUP, ST_WLOW, ST_WHOLD, ST_WGAP,
      ST_RSETUP, ST_RWAIT, ST_RDONE, ST_PWAIT
   } epw_state_type;

   epw_state_type       st_r, st_nxt;
   logic [19:0]         cnt_r, cnt_nxt;
   logic [19:0]         age_r, age_nxt;
   logic [6:0]          nbytes_r, nbytes_nxt;
   logic [6:0]          row_r, row_nxt;
   epw_req_type         cur_r, cur_nxt;
   epw_pin_type         pins_r, pins_nxt;
   logic                rdy_r, rdy_nxt;
   logic                rv_r, rv_nxt;
   epw_rsp_type         rsp_r, rsp_nxt;
   logic                perr_r, perr_nxt;
   logic [7:0]          dq_s1_r, dq_s2_r, dq_s3_r;
   logic [7:0]          dq_ok_r;

   // ----------------------------------------
   // Data input sync, three stages
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
         dq_s3_r <= 8'h00;
         dq_ok_r <= 8'h00;
      end else if (clk_en) begin
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
         dq_s3_r <= dq_s2_r;
         if (dq_s2_r == dq_s3_r) begin
            dq_ok_r <= dq_s3_r;
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      age_nxt    = (age_r == 20'hfffff) ? age_r : age_r + 20'h00001;
      nbytes_nxt = nbytes_r;
      row_nxt    = row_r;
      cur_nxt    = cur_r;
      pins_nxt   = pins_r;
      rdy_nxt    = 1'b0;
      rv_nxt     = 1'b0;
      rsp_nxt    = rsp_r;
      perr_nxt   = 1'b0;
      case (st_r)
         ST_IDLE: begin
            // Bus parked: no write combination, so device inhibited [R11]
            pins_nxt.chip_sel_n  = 1'b1;
            pins_nxt.out_gate_n  = 1'b1;
            pins_nxt.wr_strobe_n = 1'b1;
            pins_nxt.dq_oe       = 1'b0;
            rdy_nxt              = 1'b1;
            // Page closed once the device window has run out [R03] [R20]
            if (nbytes_r != 7'h00 && age_r >= 20'(`EPW_WINDOW_CYC)) begin
               nbytes_nxt = 7'h00;
            end
            if (req_valid && rdy_r) begin
               rdy_nxt = 1'b0;
               cur_nxt = req;
               pins_nxt.addr = req.addr;
               if (req.cmd == EPW_CMD_WRITE) begin
                  // Row of a later byte forced to the page row [R18] [R19]
                  // Stray row flagged; device would store it in the page row anyway
                  if (nbytes_nxt != 7'h00) begin
                     pins_nxt.addr = {row_r, req.addr[5:0]};
                     perr_nxt      = req.addr[12:`EPW_ROW_LSB] != row_r; // [R18]
                  end
                  pins_nxt.dq_out = req.data;
                  pins_nxt.dq_oe  = 1'b1;
                  pins_nxt.chip_sel_n = 1'b0;
                  cnt_nxt = 20'(`EPW_SETUP_CYC);
                  st_nxt  = ST_WSETUP;
               end else begin
                  pins_nxt.chip_sel_n = 1'b0;
                  cnt_nxt = 20'(`EPW_SETUP_CYC);
                  st_nxt  = ST_RSETUP;
               end
            end
         end
         ST_WSETUP: begin
            // Gate high before strobe falls: write combination [R16]
            if (cnt_r > 20'h00001) begin
               cnt_nxt = cnt_r - 20'h00001;
            end else begin
               pins_nxt.wr_strobe_n = 1'b0;
               cnt_nxt = 20'(`EPW_STROBE_CYC);
               st_nxt  = ST_WLOW;
            end
         end
         ST_WLOW: begin
            // Strobe low well past noise filter [R13] [R05]
            if (cnt_r > 20'h00001) begin
               cnt_nxt = cnt_r - 20'h00001;
            end else begin
               pins_nxt.wr_strobe_n = 1'b1;
               cnt_nxt = 20'(`EPW_HOLD_CYC);
               st_nxt  = ST_WHOLD;
            end
         end
         ST_WHOLD: begin
            // Data held past rising edge, device latches it here [R01] [R17]
            if (cnt_r > 20'h00001) begin
               cnt_nxt = cnt_r - 20'h00001;
            end else begin
               pins_nxt.chip_sel_n = 1'b1;
               pins_nxt.dq_oe      = 1'b0;
               if (nbytes_r == 7'h00) begin
                  row_nxt = cur_r.addr[12:`EPW_ROW_LSB];
               end
               nbytes_nxt = nbytes_r + 7'h01;
               age_nxt    = 20'h00000;
               cnt_nxt    = 20'(`EPW_LOAD_GAP_CYC);
               st_nxt     = ST_WGAP;
            end
         end
         ST_WGAP: begin
            // Least spacing between loads; well inside the window [R14] [R06]
            if (cnt_r > 20'h00001) begin
               cnt_nxt = cnt_r - 20'h00001;
            end else begin
               rv_nxt = 1'b1;
               rsp_nxt.timeout = 1'b0;
               // Full page or last byte: age set to the load gap, page stays open until the window lapses [R03] [R19]
               if (cur_r.last || nbytes_r == 7'(`EPW_PAGE_BYTES)) begin
                  age_nxt = 20'(`EPW_LOAD_GAP_CYC);
               end
               st_nxt = ST_IDLE;
            end
         end
         ST_RSETUP: begin
            // Ordinary read, strobe stays high [R10] [R16]
            pins_nxt.out_gate_n = 1'b0;
            // Poll no sooner than the load-to-poll delay [R15] [R09]
            cnt_nxt = 20'(`EPW_READ_CYC + `EPW_POLL_DLY_CYC + 3);
            st_nxt  = ST_RWAIT;
         end
         ST_RWAIT: begin
            if (cnt_r > 20'h00001) begin
               cnt_nxt = cnt_r - 20'h00001;
            end else begin
               st_nxt = ST_RDONE;
            end
         end
         ST_RDONE: begin
            pins_nxt.out_gate_n = 1'b1;
            pins_nxt.chip_sel_n = 1'b1;
            if (cur_r.cmd == EPW_CMD_POLL && dq_ok_r != cur_r.data) begin
               // Inverted byte means still programming; read again, or time out once window plus program time has passed [R07] [R08]
               if (age_r >= 20'(`EPW_WINDOW_CYC + `EPW_PROGRAM_CYC)) begin
                  rv_nxt = 1'b1;
                  rsp_nxt.data = dq_ok_r;
                  rsp_nxt.timeout = 1'b1;
                  st_nxt = ST_IDLE;
               end else begin
                  cnt_nxt = 20'(`EPW_SETUP_CYC);
                  st_nxt  = ST_PWAIT;
               end
            end else begin
               // Match ends the program; next page starts fresh [R04] [R20]
               if (cur_r.cmd == EPW_CMD_POLL) begin
                  nbytes_nxt = 7'h00;
               end
               rv_nxt = 1'b1;
               rsp_nxt.data = dq_ok_r;
               rsp_nxt.timeout = 1'b0;
               st_nxt = ST_IDLE;
            end
         end
         ST_PWAIT: begin
            // Chip deselected between polls so each is a full read cycle
            if (cnt_r > 20'h00001) begin
               cnt_nxt = cnt_r - 20'h00001;
            end else begin
               pins_nxt.chip_sel_n = 1'b0;
               st_nxt = ST_RSETUP;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r     <= ST_IDLE;
         cnt_r    <= 20'h00000;
         age_r    <= 20'hfffff;
         nbytes_r <= 7'h00;
         row_r    <= 7'h00;
         cur_r    <= '0;
         pins_r   <= '{chip_sel_n: 1'b1, out_gate_n: 1'b1, wr_strobe_n: 1'b1,
                       addr: 13'h0000, dq_out: 8'h00, dq_oe: 1'b0};
         rdy_r    <= 1'b0;
         rv_r     <= 1'b0;
         rsp_r    <= '0;
         perr_r   <= 1'b0;
      end else if (clk_en) begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         age_r    <= age_nxt;
         nbytes_r <= nbytes_nxt;
         row_r    <= row_nxt;
         cur_r    <= cur_nxt;
         pins_r   <= pins_nxt;
         rdy_r    <= rdy_nxt;
         rv_r     <= rv_nxt;
         rsp_r    <= rsp_nxt;
         perr_r   <= perr_nxt;
      end
   end

   assign pins       = pins_r;
   assign req_ready  = rdy_r;
   assign rsp_valid  = rv_r;
   assign rsp        = rsp_r;
   assign page_error = perr_r;
endmodule

// File: epw_host_checker.sv
`timescale 1ns/1ps
module epw_host_checker
   import epw_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   // Requests
   input wire logic        req_valid,
   input wire epw_req_type req,
   input wire logic        req_ready,
   input wire logic        rsp_valid,
   input wire epw_rsp_type rsp,
   input wire logic        page_error,
   // Pins
   input wire epw_pin_type pins,
   input wire logic [7:0]  dq_in
);
   epw_req_type held_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) held_r <= '0;
      else if (clk_en && req_valid && req_ready) held_r <= req;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_wcombo; !pins.wr_strobe_n |-> !pins.chip_sel_n && pins.out_gate_n && pins.dq_oe; endproperty
   a_wcombo: assert property (p_wcombo) else $error("strobe low outside write select");
   property p_rdpins; !pins.out_gate_n |-> !pins.chip_sel_n && pins.wr_strobe_n && !pins.dq_oe
      && pins.addr == held_r.addr; endproperty
   a_rdpins: assert property (p_rdpins) else $error("read pins wrong");
   property p_width; $fell(pins.wr_strobe_n) |-> !pins.wr_strobe_n ##1 !pins.wr_strobe_n; endproperty
   a_width: assert property (p_width) else $error("strobe pulse too short");
   property p_hold; !pins.wr_strobe_n && !$past(pins.wr_strobe_n) |-> $stable(pins.addr) && $stable(pins.dq_out);
   endproperty
   a_hold: assert property (p_hold) else $error("address or data moved under strobe");
   property p_gap; $rose(pins.wr_strobe_n) |-> (pins.wr_strobe_n && pins.dq_oe) ##1 pins.wr_strobe_n; endproperty
   a_gap: assert property (p_gap) else $error("loads too close");
   property p_take; clk_en && req_valid && req_ready && req.cmd == EPW_CMD_WRITE |-> ##[1:3] !pins.wr_strobe_n;
   endproperty
   a_take: assert property (p_take) else $error("write not launched");
   property p_data; $fell(pins.wr_strobe_n) |-> pins.addr[5:0] == held_r.addr[5:0] && pins.dq_out == held_r.data;
   endproperty
   a_data: assert property (p_data) else $error("wrong address or data");
   property p_freeze; !clk_en |=> $stable(pins) && $stable(rsp_valid) && $stable(req_ready); endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
   property p_poll; rsp_valid && !rsp.timeout && held_r.cmd == EPW_CMD_POLL |-> rsp.data == held_r.data; endproperty
   a_poll: assert property (p_poll) else $error("poll ended early");
endmodule
bind epw_host epw_host_checker epw_host_checker_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
   .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
   .page_error(page_error), .pins(pins), .dq_in(dq_in));

// File: epw_pkg.sv
package epw_pkg;
   typedef enum logic [1:0] {
      EPW_CMD_READ,
      EPW_CMD_WRITE,
      EPW_CMD_POLL
   } epw_cmd_type;

   typedef struct packed {
      epw_cmd_type cmd;
      logic [12:0] addr;
      logic [7:0]  data;
      logic        last;
   } epw_req_type;

   typedef struct packed {
      logic [7:0] data;
      logic       timeout;
   } epw_rsp_type;

   typedef struct packed {
      logic        chip_sel_n;
      logic        out_gate_n;
      logic        wr_strobe_n;
      logic [12:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe;
   } epw_pin_type;
endpackage

// File: tb.sv
`timescale 1ns/1ps
module tb;
   import epw_pkg::*;
   logic mclk, rst_n, clk_en, req_valid, req_ready, rsp_valid, page_error, pe;
   epw_req_type req;
   epw_rsp_type rsp;
   epw_pin_type pins;
   logic [7:0]  dq_in, d, sm [0:8191];
   logic [15:0] lf;
   logic [12:0] a, ad;
   logic [5:0]  m;
   int          fails, samples_checked, cyc, sz [3];
   epw_host epw_host_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .page_error(page_error), .pins(pins), .dq_in(dq_in));
   epw_dev_model epw_dev_model_inst (.pins(pins), .mclk(mclk), .dq_in(dq_in));
   always #50 mclk = ~mclk;
   function automatic logic [15:0] nx(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Bounded run, a hang counts as a mismatch
   always @(posedge mclk) if (++cyc == 40000) begin
      fails++;
      stop_test();
   end
   task automatic op(epw_cmd_type c, logic [12:0] ad, logic [7:0] dt, logic lst);
      @(negedge mclk);
      req = '{c, ad, dt, lst};
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      pe = page_error;
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(negedge mclk);
   endtask
   task automatic rst;
      rst_n = 1'b0;
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
   endtask
   initial begin
      {mclk, req_valid, fails, samples_checked, cyc} = '0;
      clk_en = 1'b1;
      req = '0;
      lf = 16'hc6b8;
      sz = '{1, 64, 5};
      foreach (sm[i]) sm[i] = 8'hff;
      rst();
      op(EPW_CMD_READ, 13'h0155, 8'h00, 1'b0);
      chk("erased", rsp.data, sm[13'h0155]);
      foreach (sz[k]) begin
         lf = nx(lf);
         a = lf[12:0];
         m = lf[15:10];
         for (int i = 0; i < sz[k]; i++) begin
            lf = nx(lf);
            d = lf[7:0];
            ad = {a[12:6], 6'(i) ^ m};
            op(EPW_CMD_WRITE, ad ^ {i == 1, 12'h000}, d, i == sz[k] - 1);
            chk("page_error", {7'h00, pe}, {7'h00, i == 1});
            sm[ad] = d;
         end
         op(EPW_CMD_READ, ~ad, 8'h00, 1'b0);
         chk("early_poll", rsp.data, ~d);
         // Let the quiet window pass so the program is running
         repeat (2000) @(negedge mclk);
         // Pause the host; its window age stalls while the device runs on
         clk_en = 1'b0;
         repeat (50) @(negedge mclk);
         clk_en = 1'b1;
         repeat (100) @(negedge mclk);
         op(EPW_CMD_WRITE, ad ^ 13'h1000, ~d, 1'b1);
         op(EPW_CMD_POLL, ad, d, 1'b1);
         chk("poll", rsp.data, d);
         chk("timeout", {7'h00, rsp.timeout}, 8'h00);
         for (int i = 0; i < sz[k]; i++) begin
            op(EPW_CMD_READ, {a[12:6], 6'(i) ^ m}, 8'h00, 1'b0);
            chk("stored", rsp.data, sm[{a[12:6], 6'(i) ^ m}]);
         end
         op(EPW_CMD_READ, ad ^ 13'h1000, 8'h00, 1'b0);
         chk("ignored", rsp.data, sm[ad ^ 13'h1000]);
      end
      rst();
      op(EPW_CMD_READ, ad, 8'h00, 1'b0);
      chk("after_reset", rsp.data, sm[ad]);
      stop_test();
   end
endmodule
